// File: bench/pd_far_side.sv
/*
  far-side model: powered devices on four ports and the test oscillator.
  assumes: controlled by the bench; outputs are asynchronous to the clock.
*/
`timescale 1ns/1ps
module pd_far_side #(
  parameter real half_ns = 64.0
) (
  // controls from the bench
  input wire logic osc_run,
  input wire logic [3:0] pd_dc,
  input wire logic [3:0] pd_ac,
  // comparator and sense outputs
  output logic osc_sense_low,
  output logic osc_sense_high,
  output logic [3:0] dc_current_ok,
  output logic [3:0] ac_period_end,
  output logic [3:0] ac_min_current
);
  // ==========================================
  // oscillator: crosses both levels each period
  logic ph = 1'b0;
  always #(half_ns) ph = ~ph;
  // a stopped oscillator sits between the two thresholds
  assign osc_sense_low = osc_run & ph;
  assign osc_sense_high = osc_run & ~ph;
  assign ac_period_end = {4{osc_run & ph}};
  assign ac_min_current = osc_run ? pd_ac : 4'h0;
  assign dc_current_ok = pd_dc;
endmodule : pd_far_side

// File: bench/test_ac_disconnect_timer_control.sv
/*
  testbench for the removal timer control: registers, timeouts, keep-alive
  paths and oscillator monitor, compared with an integer model.
  assumes: pd_far_side model; shortened window and timeout parameters.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module test_ac_disconnect_timer_control;
  localparam logic [4:0] ena = acdis_pkg::disconnect_enable_control_off;
  localparam logic [4:0] tma = acdis_pkg::disconnect_timing_config_off;
  localparam logic [4:0] sea = acdis_pkg::supply_event_off;
  localparam logic [4:0] mka = acdis_pkg::osc_fail_mask_off;
  logic clock, rst_n, soft_reset, reg_wr, reg_rd, osc_irq, osc_run;
  logic osc_sense_low, osc_sense_high;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val, en;
  logic [3:0] port_on_cmd, dc_current_ok, ac_period_end, ac_min_current;
  logic [3:0] port_power, disconnect_fault, pd_dc, pd_ac;
  logic [31:0] seed = 32'h8C79;
  int fail_count = 0;
  int n_tests = 0;
  int lim[4] = '{20, 30, 40, 50};
  int n;

  ac_disconnect_timer_control #(.osc_window_len(64), .removal_len_0(20),
    .removal_len_1(30), .removal_len_2(40), .removal_len_3(50)) DUT (
    .clock(clock), .rst_n(rst_n), .soft_reset(soft_reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .osc_sense_low(osc_sense_low), .osc_sense_high(osc_sense_high),
    .port_on_cmd(port_on_cmd), .dc_current_ok(dc_current_ok),
    .ac_period_end(ac_period_end), .ac_min_current(ac_min_current),
    .port_power(port_power), .disconnect_fault(disconnect_fault),
    .osc_irq(osc_irq));
  pd_far_side far (.osc_run(osc_run), .pd_dc(pd_dc), .pd_ac(pd_ac),
    .osc_sense_low(osc_sense_low), .osc_sense_high(osc_sense_high),
    .dc_current_ok(dc_current_ok), .ac_period_end(ac_period_end),
    .ac_min_current(ac_min_current));

  // ==========================================
  // model and helpers
  function automatic logic [3:0] keep(logic [7:0] e, logic [3:0] d,
    logic [3:0] a, logic o);
    return (e[3:0] & d) | (e[7:4] & a & {4{o}});
  endfunction : keep
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic cyc(int c);
    repeat (c) @(negedge clock);
  endtask : cyc
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(logic [4:0] a);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    rd_val = reg_rdata;
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // ==========================================
  // clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    soft_reset = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    port_on_cmd = 4'h0;
    osc_run = 1'b1;
    pd_dc = 4'h0;
    pd_ac = 4'h0;
    cyc(2);
    rst_n = 1'b1;
    rd(ena);
    `CHK(rd_val, acdis_pkg::enable_reset)
    rd(mka);
    `CHK(rd_val, acdis_pkg::mask_reset)
    rd(5'h1F);
    `CHK(rd_val, 8'h00)
    `CHK(osc_irq, 1'b1)
    wr(sea, 8'h02);
    cyc(200);
    `CHK(osc_irq, 1'b0)
    rd(sea);
    `CHK(rd_val[acdis_pkg::osc_fail_pos], 1'b0)
    osc_run = 1'b0;
    cyc(200);
    `CHK(osc_irq, 1'b1)
    wr(mka, 8'h00);
    wr(sea, 8'h02);
    cyc(200);
    `CHK(osc_irq, 1'b0)
    wr(mka, acdis_pkg::mask_reset);
    // every timeout code, no keep-alive at all
    for (int s = 0; s < 4; s++) begin
      port_on_cmd = 4'h0;
      wr(tma, 8'(s));
      rd(tma);
      `CHK(rd_val, 8'(s))
      port_on_cmd = 4'hF;
      n = 0;
      while ((port_power !== 4'h0 || n < 3) && n < 300) begin
        cyc(1);
        n++;
      end
      `CHK(n >= lim[s] && n <= lim[s] + 6, 1'b1)
    end
    `CHK(disconnect_fault, 4'hF)
    // enable and presence mixes, longest timeout kept
    osc_run = 1'b1;
    for (int r = 0; r < 4; r++) begin
      en = r == 3 ? 8'h6D : 8'h00;
      pd_dc = r == 3 ? 4'h1 : 4'hF;
      pd_ac = 4'hF;
      if (r < 2) begin
        seed = xs(seed);
        en = seed[7:0];
        pd_dc = seed[11:8];
        pd_ac = seed[15:12];
      end
      port_on_cmd = 4'h0;
      wr(ena, en);
      port_on_cmd = 4'hF;
      cyc(200);
      `CHK(port_power, keep(en, pd_dc, pd_ac, 1'b1))
    end
    osc_run = 1'b0;
    cyc(200);
    `CHK(port_power, keep(8'h6D, 4'h1, 4'hF, 1'b0))
    `CHK(port_power[0], 1'b1)
    osc_run = 1'b1;
    // let a window that still saw the stopped oscillator end first
    cyc(100);
    wr(sea, 8'h02);
    cyc(200);
    `CHK(osc_irq, 1'b0)
    soft_reset = 1'b1;
    cyc(1);
    soft_reset = 1'b0;
    cyc(2);
    `CHK(osc_irq, 1'b1)
    rd(ena);
    `CHK(rd_val, acdis_pkg::enable_reset)
    end_of_test();
  end
endmodule : test_ac_disconnect_timer_control

// File: logic/ac_disconnect_timer_control.sv
/*
  four-port removal timer control with ac and dc keep-alive paths and an
  oscillator activity monitor.
  assumes: comparator outputs arrive from the analog side asynchronously;
  register port is a simple byte-wide strobe interface on this clock.
*/
`timescale 1ns/1ps
module ac_disconnect_timer_control #(
  parameter int osc_window_len = acdis_pkg::osc_window_cycles,
  parameter int removal_len_0 = acdis_pkg::removal_cycles_0,
  parameter int removal_len_1 = acdis_pkg::removal_cycles_1,
  parameter int removal_len_2 = acdis_pkg::removal_cycles_2,
  parameter int removal_len_3 = acdis_pkg::removal_cycles_3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic soft_reset,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // oscillator comparators
  input wire logic osc_sense_low,
  input wire logic osc_sense_high,
  // per-port command and analog status
  input wire logic [3:0] port_on_cmd,
  input wire logic [3:0] dc_current_ok,
  input wire logic [3:0] ac_period_end,
  input wire logic [3:0] ac_min_current,
  // results
  output logic [3:0] port_power,
  output logic [3:0] disconnect_fault,
  output logic osc_irq
);
  localparam int np = acdis_pkg::num_ports;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] timing;
    logic [7:0] mask;
    logic osc_fail;
    logic [31:0] win_count;
    logic seen_low;
    logic seen_high;
    logic [3:0] power;
    logic [3:0] fault;
    logic [3:0] end_d;
    logic [3:0] cmd_d;
    logic [7:0] rdata;
    logic irq;
    logic init;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;

  // ===========================================================
  // input synchronisers
  logic osc_low_s;
  logic osc_high_s;
  logic [3:0] dc_ok_s;
  logic [3:0] ac_end_s;
  logic [3:0] ac_cur_s;

  sync3 u_sync_low (
    .clock(clock), .rst_n(rst_n), .async_in(osc_sense_low),
    .sync_out(osc_low_s)
  );
  sync3 u_sync_high (
    .clock(clock), .rst_n(rst_n), .async_in(osc_sense_high),
    .sync_out(osc_high_s)
  );

  logic [3:0] ac_pulse;
  logic [3:0] dc_keep;
  logic [3:0] keep_alive;
  logic [3:0] expire;
  logic [31:0] limit;

  // ===========================================================
  // timeout select
  always_comb begin
    unique case (st_reg.timing[acdis_pkg::timeout_sel_hi_pos -: 2])
      2'h0: limit = 32'(removal_len_0);
      2'h1: limit = 32'(removal_len_1);
      2'h2: limit = 32'(removal_len_2);
      2'h3: limit = 32'(removal_len_3);
    endcase
  end

  // ===========================================================
  // per-port keep-alive and timers
  for (genvar p = 0; p < np; p++) begin : g_port
    sync3 u_dc (
      .clock(clock), .rst_n(rst_n), .async_in(dc_current_ok[p]),
      .sync_out(dc_ok_s[p])
    );
    sync3 u_end (
      .clock(clock), .rst_n(rst_n), .async_in(ac_period_end[p]),
      .sync_out(ac_end_s[p])
    );
    sync3 u_cur (
      .clock(clock), .rst_n(rst_n), .async_in(ac_min_current[p]),
      .sync_out(ac_cur_s[p])
    );
    // one keep-alive pulse per period when the minimum current was met
    assign ac_pulse[p] = ac_end_s[p] & ~st_reg.end_d[p]
                       & ac_cur_s[p]
                       & st_reg.enable[acdis_pkg::ac_sense_en_pos + p];
    assign dc_keep[p] = dc_ok_s[p]
                      & st_reg.enable[acdis_pkg::dc_sense_en_pos + p];
    // with both paths off the timer is never fed and the port drops
    assign keep_alive[p] = ac_pulse[p] | dc_keep[p];
    port_removal_timer u_timer (
      .clock(clock), .rst_n(rst_n), .powered(st_reg.power[p]),
      .keep_alive(keep_alive[p]), .limit(limit), .expire(expire[p])
    );
  end

  // ===========================================================
  // control state
  logic win_end;
  assign win_end = (st_reg.win_count + 32'h00000001
                    >= 32'(osc_window_len));

  always_comb begin
    st_next = st_reg;
    st_next.init = 1'b0;
    st_next.end_d = ac_end_s;
    st_next.cmd_d = port_on_cmd;
    // window counter with crossing latches
    if (win_end) begin
      st_next.win_count = 32'h00000000;
      st_next.seen_low = 1'b0;
      st_next.seen_high = 1'b0;
    end else begin
      st_next.win_count = st_reg.win_count + 32'h00000001;
      st_next.seen_low = st_reg.seen_low | osc_low_s;
      st_next.seen_high = st_reg.seen_high | osc_high_s;
    end
    // a rising command powers a port; expiry drops it until the next rise,
    // so a held command cannot re-power a removed device
    for (int i = 0; i < np; i++) begin
      if (expire[i]) begin
        st_next.power[i] = 1'b0;
        st_next.fault[i] = 1'b1;
      end else if (port_on_cmd[i] && !st_reg.cmd_d[i]
                   && !st_reg.power[i]) begin
        st_next.power[i] = 1'b1;
      end
    end
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        acdis_pkg::disconnect_enable_control_off: st_next.enable = reg_wdata;
        acdis_pkg::disconnect_timing_config_off: st_next.timing = reg_wdata;
        acdis_pkg::osc_fail_mask_off: st_next.mask = reg_wdata;
        acdis_pkg::supply_event_off: begin
          if (reg_wdata[acdis_pkg::osc_fail_pos]) begin
            st_next.osc_fail = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // set wins over clear
    if (win_end && !(st_reg.seen_low && st_reg.seen_high)
        && st_reg.mask[acdis_pkg::osc_fail_pos]) begin
      st_next.osc_fail = 1'b1;
    end
    // flag drives the interrupt output and is also read back at the supply event offset
    st_next.irq = st_next.osc_fail;
    if (reg_rd) begin
      unique case (reg_addr)
        acdis_pkg::disconnect_enable_control_off: st_next.rdata = st_reg.enable;
        acdis_pkg::disconnect_timing_config_off: st_next.rdata = st_reg.timing;
        acdis_pkg::osc_fail_mask_off: st_next.rdata = st_reg.mask;
        acdis_pkg::supply_event_off:
          st_next.rdata = {6'h00, st_reg.osc_fail, 1'b0};
        default: st_next.rdata = 8'h00;
      endcase
    end
    if (soft_reset) begin
      st_next.enable = acdis_pkg::enable_reset;
      st_next.timing = acdis_pkg::timing_reset;
      st_next.mask = acdis_pkg::mask_reset;
      st_next.osc_fail = 1'b1;
      st_next.power = 4'h0;
      st_next.fault = 4'h0;
      st_next.irq = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.enable <= acdis_pkg::enable_reset;
      st_reg.timing <= acdis_pkg::timing_reset;
      st_reg.mask <= acdis_pkg::mask_reset;
      st_reg.osc_fail <= 1'b1;
      st_reg.irq <= 1'b1;
      st_reg.init <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign port_power = st_reg.power;
  assign disconnect_fault = st_reg.fault;
  assign osc_irq = st_reg.irq;

  // ===========================================================
  // checks on the oscillator flag and its interrupt
  a_osc_flag_set: assert property (
    win_end && !(st_reg.seen_low && st_reg.seen_high)
    && st_reg.mask[acdis_pkg::osc_fail_pos] |=> st_reg.osc_fail)
    else $error("oscillator fault not flagged");
  a_osc_flag_hold: assert property (
    !st_reg.osc_fail && $past(st_reg.osc_fail) == 1'b0 && !soft_reset
    && !win_end |=> !st_reg.osc_fail)
    else $error("oscillator flag set without cause");
  a_mask_blocks: assert property (
    !st_reg.osc_fail && !st_reg.mask[acdis_pkg::osc_fail_pos]
    && !soft_reset |=> !st_reg.osc_fail)
    else $error("masked oscillator fault set the flag");
  a_flag_clear: assert property (
    reg_wr && reg_addr == acdis_pkg::supply_event_off
    && reg_wdata[acdis_pkg::osc_fail_pos] && !soft_reset
    && !(win_end && !(st_reg.seen_low && st_reg.seen_high))
    |=> !st_reg.osc_fail)
    else $error("oscillator flag did not clear");
  a_irq_follows: assert property (
    st_reg.irq == st_reg.osc_fail)
    else $error("interrupt not tied to flag");
  a_reset_flag_set: assert property (
    st_reg.init |-> st_reg.osc_fail && osc_irq)
    else $error("reset did not set oscillator flag");
  a_soft_reset_flag: assert property (
    soft_reset |=> st_reg.osc_fail && st_reg.power == 4'h0)
    else $error("soft reset did not set flag");
  a_rdata_flag: assert property (
    reg_rd && reg_addr == acdis_pkg::supply_event_off
    |=> reg_rdata[acdis_pkg::osc_fail_pos] == $past(st_reg.osc_fail))
    else $error("flag read back wrong");
  a_win_restart: assert property (
    win_end |=> st_reg.win_count == 32'h00000000
    && !st_reg.seen_low && !st_reg.seen_high)
    else $error("oscillator window did not restart");

  // ===========================================================
  // checks on the keep-alive paths and the timers
  a_timeout_select: assert property (
    st_reg.timing[acdis_pkg::timeout_sel_hi_pos -: 2] == 2'h1
    |-> limit == 32'(removal_len_1))
    else $error("wrong removal timeout selected");
  a_expire_drops: assert property (
    expire[0] && !soft_reset |=> !st_reg.power[0] && st_reg.fault[0])
    else $error("expiry did not drop port");
  a_fault_sticky: assert property (
    st_reg.fault[2] && !soft_reset |=> st_reg.fault[2])
    else $error("removal fault flag lost");
  a_power_hold: assert property (
    !expire[0] && !soft_reset && !(port_on_cmd[0] && !st_reg.cmd_d[0])
    |=> st_reg.power[0] == $past(st_reg.power[0]))
    else $error("port power changed without cause");
  a_power_cmd_rise: assert property (
    port_on_cmd[1] && !st_reg.cmd_d[1] && !expire[1] && !soft_reset
    |=> st_reg.power[1])
    else $error("port did not power on command");
  a_ac_gated: assert property (
    !st_reg.enable[acdis_pkg::ac_sense_en_pos]
    && !st_reg.enable[acdis_pkg::dc_sense_en_pos] |-> !keep_alive[0])
    else $error("disabled path fed timer");
  a_ac_off_no_pulse: assert property (
    !st_reg.enable[acdis_pkg::ac_sense_en_pos + 3] |-> !ac_pulse[3])
    else $error("disabled ac path pulsed");
  a_dc_off_no_feed: assert property (
    !st_reg.enable[acdis_pkg::dc_sense_en_pos + 3] |-> !dc_keep[3])
    else $error("disabled dc path fed timer");
  a_dc_feeds: assert property (
    dc_ok_s[1] && st_reg.enable[acdis_pkg::dc_sense_en_pos + 1]
    |-> keep_alive[1])
    else $error("dc path did not feed timer");
  a_keep_no_expire: assert property (
    keep_alive[1] |=> !expire[1])
    else $error("fed timer expired");
  a_ac_pulse_once: assert property (
    ac_pulse[2] |=> !ac_pulse[2])
    else $error("ac path held timer continuously");
  a_ac_needs_current: assert property (
    ac_pulse[2] |-> ac_cur_s[2])
    else $error("ac pulse without minimum current");
endmodule : ac_disconnect_timer_control

// File: logic/acdis_pkg.sv
/*
  package: register offsets, field positions, reset values and timing
  counts for the port removal timer block.
  assumes: 125 MHz clock; register access by a plain byte-wide port.
*/
package acdis_pkg;
  // register offsets on the byte-wide register port
  localparam logic [4:0] disconnect_enable_control_off = 5'h13;
  localparam logic [4:0] disconnect_timing_config_off = 5'h16;
  localparam logic [4:0] supply_event_off = 5'h0A;
  localparam logic [4:0] osc_fail_mask_off = 5'h0B;
  // field positions
  localparam int dc_sense_en_pos = 0;
  localparam int ac_sense_en_pos = 4;
  localparam int osc_fail_pos = 1;
  localparam int timeout_sel_lo_pos = 0;
  localparam int timeout_sel_hi_pos = 1;
  // reset values
  localparam logic [7:0] enable_reset = 8'hFF;
  localparam logic [7:0] timing_reset = 8'h00;
  localparam logic [7:0] mask_reset = 8'h02;
  // timing
  localparam int clock_mhz = 125;
  localparam int osc_window_ms = 250;
  localparam int osc_window_cycles = osc_window_ms * 1000 * clock_mhz;
  localparam int removal_timeout_ms_0 = 300;
  localparam int removal_timeout_ms_1 = 75;
  localparam int removal_timeout_ms_2 = 150;
  localparam int removal_timeout_ms_3 = 600;
  localparam int removal_cycles_0 = removal_timeout_ms_0 * 1000 * clock_mhz;
  localparam int removal_cycles_1 = removal_timeout_ms_1 * 1000 * clock_mhz;
  localparam int removal_cycles_2 = removal_timeout_ms_2 * 1000 * clock_mhz;
  localparam int removal_cycles_3 = removal_timeout_ms_3 * 1000 * clock_mhz;
  localparam int num_ports = 4;
endpackage : acdis_pkg

// File: logic/port_removal_timer.sv
/*
  one port's removal timer: counts while powered and no keep-alive arrives.
  assumes: keep-alive and limit come from the same clock domain.
*/
`timescale 1ns/1ps
module port_removal_timer (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic powered,
  input wire logic keep_alive,
  input wire logic [31:0] limit,
  // result
  output logic expire
);
  typedef struct packed {
    logic [31:0] count;
    logic expire;
  } timer_state_t;
  timer_state_t st_reg;
  timer_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.expire = 1'b0;
    if (!powered || keep_alive) begin
      st_next.count = 32'h00000000;
    end else if (st_reg.count + 32'h00000001 >= limit) begin
      st_next.expire = 1'b1;
      st_next.count = 32'h00000000;
    end else begin
      st_next.count = st_reg.count + 32'h00000001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expire = st_reg.expire;
endmodule : port_removal_timer

// File: logic/sync3.sv
/*
  three-flop synchroniser with agreement filter.
  assumes: asynchronous input; output changes when stages two and three agree.
*/
`timescale 1ns/1ps
module sync3 (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // data
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_state_t;
  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.q;
endmodule : sync3
